// [hw/mda_pkg.sv]
// Purpose: Shared constants and types of the mirror drive acquisition block.
// Assumes: 100 MHz system clock.
// Notes: Cycle counts are derived from times in their own units.

package mda_pkg;

  // Clock and converter timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMP_PERIOD_NS = 140;
  localparam int SAMP_CYC =
    (SAMP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Drive frequency span the generator must reach
  localparam int F_MIN_HZ = 225;
  localparam int F_MAX_HZ = 325;
  localparam int HALF_MAX_CYC = CLK_HZ / (2 * F_MIN_HZ);
  localparam int HALF_MIN_CYC = (CLK_HZ + 2 * F_MAX_HZ - 1) / (2 * F_MAX_HZ);

  // Widths
  localparam int ADC_W = 16;
  localparam int HP_W = 18;
  localparam int TEMP_W = 8;
  localparam int ZF_W = 16;
  localparam int PCNT_W = 32;

  // Margin kept below the resonant frequency, in half-period cycles
  localparam logic [HP_W-1:0] RES_MARGIN_CYC = 18'h003e8;

  // Convergence wait before readout: one strobe period plus the update pipe
  localparam int SETTLE_CYC = SAMP_CYC + 2;

  // Reset values
  localparam logic POL_RST = 1'b0;
  localparam logic HV_DRIVE_RST = 1'b0;
  localparam logic [HP_W-1:0] HALF_PER_RST = 18'h3640e;

  typedef enum logic [1:0] {DRV_IDLE, DRV_LOAD, DRV_RUN} mda_drv_state_t;

  typedef enum logic [2:0] {
    ACQ_IDLE, ACQ_WAIT, ACQ_RUN, ACQ_SETTLE, ACQ_PRE, ACQ_H0, ACQ_H1, ACQ_POST
  } mda_acq_state_t;

endpackage

// [hw/mda_fifo.sv]
// Purpose: Result FIFO with a registered output stage.
// Assumes: DEPTH is a power of two.
// Notes: Output valid and data come straight from flip-flops.

`timescale 1ns/10ps

module mda_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic in_valid, // Write request
  input wire logic [W-1:0] in_data, // Write data
  output logic in_ready, // Room for one more word
  output logic out_valid, // Output word present
  output logic [W-1:0] out_data, // Output word
  input wire logic out_ready // Consumer takes the word
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic ov_reg, ov_next;
  logic [W-1:0] od_reg, od_next;
  logic do_wr, do_rd;

  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = ov_reg;
  assign out_data = od_reg;

  always_comb begin
    do_wr = in_valid && in_ready;
    do_rd = (!ov_reg || out_ready) && (cnt_reg != '0);
    wr_ptr_next = do_wr ? wr_ptr_reg + PW'(1) : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + PW'(1) : rd_ptr_reg;
    cnt_next = cnt_reg + CW'(do_wr) - CW'(do_rd);
    od_next = do_rd ? mem[rd_ptr_reg] : od_reg;
    if (do_rd) begin
      ov_next = 1'b1;
    end else if (out_ready) begin
      ov_next = 1'b0;
    end else begin
      ov_next = ov_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      ov_reg <= 1'b0;
      od_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      ov_reg <= ov_next;
      od_reg <= od_next;
    end
  end

endmodule

// [hw/mda_top.sv]
// Purpose: Mirror drive sequencer and interferogram accumulator.
// Assumes: Converters answer a strobe with adc_done within 13 cycles.
// Notes: Accumulated record streams out through an 8-word FIFO.

`timescale 1ns/10ps

module mda_top
  import mda_pkg::*;
#(
  parameter int MAX_CYC = 1024,
  parameter int HALF_DEPTH = 512,
  parameter int FIFO_DEPTH = 8,
  parameter int HALF_MIN = mda_pkg::HALF_MIN_CYC,
  parameter int HALF_MAX = mda_pkg::HALF_MAX_CYC,
  localparam int ACC_W = mda_pkg::ADC_W + $clog2(MAX_CYC),
  localparam int CYC_W = $clog2(MAX_CYC) + 1,
  localparam int IDX_W = $clog2(HALF_DEPTH) + 1,
  localparam int OUT_W = 2 * ACC_W + 1
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic drive_start, // Start mirror drive, pulse
  input wire logic drive_stop, // Stop mirror drive, pulse
  input wire logic [mda_pkg::TEMP_W-1:0] temp_code, // Thermistor reading
  input wire logic temp_valid, // New temperature reading, pulse
  input wire logic [mda_pkg::HP_W-1:0] res_half_period, // Resonance half
  output logic nvm_rd_en, // Condition memory read, pulse
  output logic [mda_pkg::TEMP_W-1:0] nvm_addr, // Condition memory address
  input wire logic nvm_rd_valid, // Condition word returned, pulse
  input wire logic [mda_pkg::HP_W-1:0] nvm_rd_data, // Drive half period
  output logic hv_enable, // Mirror driver enable
  output logic hv_drive, // Square-wave drive level
  output logic [mda_pkg::PCNT_W-1:0] pulse_count, // Pulses since start
  output logic [mda_pkg::HP_W-1:0] half_period, // Half period in use
  output logic drive_running, // Drive active
  output logic adc_strobe, // Shared converter strobe, pulse
  input wire logic adc_done, // Converter pair ready, pulse
  input wire logic [mda_pkg::ADC_W-1:0] adc_ir_data, // Infrared sample
  input wire logic [mda_pkg::ADC_W-1:0] adc_laser_data, // Laser sample
  input wire logic acq_start, // Start acquisition, pulse
  input wire logic [CYC_W-1:0] cycle_target, // Mirror cycles to sum
  input wire logic [IDX_W-1:0] peak_samples, // Valid samples per half
  input wire logic [mda_pkg::ZF_W-1:0] zero_fill, // Zeros at each end
  output logic acq_busy, // Acquisition in progress
  output logic acq_done, // Record fully queued, pulse
  output logic out_valid, // Result word present
  output logic [OUT_W-1:0] out_data, // {infrared, laser, direction}
  input wire logic out_ready // Consumer takes result word
);

  import mda_pkg::*;

  localparam int AW = IDX_W;
  localparam logic [HP_W-1:0] HP_LO = HP_W'(HALF_MIN);
  localparam logic [HP_W-1:0] HP_HI = HP_W'(HALF_MAX);
  localparam logic [4:0] SAMP_LAST = 5'(SAMP_CYC - 1);
  localparam logic [IDX_W-1:0] IDX_MAX = IDX_W'(HALF_DEPTH);
  localparam logic [CYC_W-1:0] CYC_MAX = CYC_W'(MAX_CYC);
  localparam logic [ZF_W-1:0] SETTLE_LAST = ZF_W'(SETTLE_CYC - 1);

  function automatic logic [HP_W-1:0] pick_half(
    input logic [HP_W-1:0] raw, input logic [HP_W-1:0] res);
    logic [HP_W-1:0] v;
    logic [HP_W-1:0] floor_v;
    v = raw;
    floor_v = res + RES_MARGIN_CYC;
    if (v < HP_LO) v = HP_LO;
    if (v > HP_HI) v = HP_HI;
    // Longer half period means lower frequency: never at or above resonance
    if (v < floor_v) v = floor_v;
    return v;
  endfunction

  function automatic logic [ACC_W-1:0] sext(input logic [ADC_W-1:0] s);
    return {{(ACC_W - ADC_W){s[ADC_W-1]}}, s};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mirror drive
  mda_drv_state_t drv_state_reg, drv_state_next;
  logic [HP_W-1:0] half_per_reg, half_per_next, half_cnt_reg, half_cnt_next;
  logic [HP_W-1:0] pend_per_reg, pend_per_next;
  logic pend_vld_reg, pend_vld_next, temp_busy_reg, temp_busy_next;
  logic hv_drive_reg, hv_drive_next, hv_en_reg, hv_en_next;
  logic pol_reg, pol_next, nvm_rd_reg, nvm_rd_next;
  logic [TEMP_W-1:0] nvm_addr_reg, nvm_addr_next;
  logic [PCNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;
  logic half_edge, rise_edge;

  assign half_edge = hv_en_reg && (half_cnt_reg == half_per_reg - HP_W'(1));
  assign rise_edge = half_edge && !hv_drive_reg;

  always_comb begin
    drv_state_next = drv_state_reg;
    half_per_next = half_per_reg;
    half_cnt_next = half_cnt_reg;
    pend_per_next = pend_per_reg;
    pend_vld_next = pend_vld_reg;
    temp_busy_next = temp_busy_reg;
    hv_drive_next = hv_drive_reg;
    hv_en_next = hv_en_reg;
    pol_next = pol_reg;
    nvm_rd_next = 1'b0;
    nvm_addr_next = nvm_addr_reg;
    pulse_cnt_next = pulse_cnt_reg;
    case (drv_state_reg)
      DRV_IDLE: begin
        if (drive_start) begin
          drv_state_next = DRV_LOAD;
          nvm_rd_next = 1'b1;
          nvm_addr_next = temp_code;
          pol_next = ~pol_reg;
          pulse_cnt_next = '0;
        end
      end
      DRV_LOAD: begin
        if (drive_stop) begin
          drv_state_next = DRV_IDLE;
        end else if (nvm_rd_valid) begin
          half_per_next = pick_half(nvm_rd_data, res_half_period);
          half_cnt_next = '0;
          hv_drive_next = 1'b1;
          hv_en_next = 1'b1;
          pulse_cnt_next = PCNT_W'(1);
          drv_state_next = DRV_RUN;
        end
      end
      DRV_RUN: begin
        if (drive_stop) begin
          drv_state_next = DRV_IDLE;
          hv_en_next = 1'b0;
          hv_drive_next = HV_DRIVE_RST;
          pend_vld_next = 1'b0;
          temp_busy_next = 1'b0;
        end else begin
          if (half_edge) begin
            half_cnt_next = '0;
            hv_drive_next = ~hv_drive_reg;
            if (!hv_drive_reg) begin
              pulse_cnt_next = pulse_cnt_reg + PCNT_W'(1);
            end
            // New period applies on an edge so no half is ever cut short
            if (pend_vld_reg) begin
              half_per_next = pend_per_reg;
              pend_vld_next = 1'b0;
            end
          end else begin
            half_cnt_next = half_cnt_reg + HP_W'(1);
          end
          if (temp_valid && !temp_busy_reg) begin
            nvm_rd_next = 1'b1;
            nvm_addr_next = temp_code;
            temp_busy_next = 1'b1;
          end
          if (temp_busy_reg && nvm_rd_valid) begin
            pend_per_next = pick_half(nvm_rd_data, res_half_period);
            pend_vld_next = 1'b1;
            temp_busy_next = 1'b0;
          end
        end
      end
      default: drv_state_next = DRV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_state_reg <= DRV_IDLE;
      half_per_reg <= HALF_PER_RST;
      half_cnt_reg <= '0;
      pend_per_reg <= HALF_PER_RST;
      pend_vld_reg <= 1'b0;
      temp_busy_reg <= 1'b0;
      hv_drive_reg <= HV_DRIVE_RST;
      hv_en_reg <= 1'b0;
      pol_reg <= POL_RST;
      nvm_rd_reg <= 1'b0;
      nvm_addr_reg <= '0;
      pulse_cnt_reg <= '0;
    end else begin
      drv_state_reg <= drv_state_next;
      half_per_reg <= half_per_next;
      half_cnt_reg <= half_cnt_next;
      pend_per_reg <= pend_per_next;
      pend_vld_reg <= pend_vld_next;
      temp_busy_reg <= temp_busy_next;
      hv_drive_reg <= hv_drive_next;
      hv_en_reg <= hv_en_next;
      pol_reg <= pol_next;
      nvm_rd_reg <= nvm_rd_next;
      nvm_addr_reg <= nvm_addr_next;
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling strobe and sample tagging
  mda_acq_state_t acq_state_reg, acq_state_next;
  logic [4:0] samp_cnt_reg, samp_cnt_next;
  logic strobe_reg, strobe_next;
  logic [IDX_W-1:0] sidx_reg, sidx_next, peak_reg, peak_next;
  logic [AW-1:0] tag_addr_reg, tag_addr_next;
  logic tag_ok_reg, tag_ok_next, tag_first_reg, tag_first_next;
  logic [CYC_W-1:0] cyc_cnt_reg, cyc_cnt_next, cyc_tgt_reg, cyc_tgt_next;
  logic [IDX_W-1:0] idx_now;
  logic half_now;

  always_comb begin
    samp_cnt_next = '0;
    strobe_next = 1'b0;
    // No strobe on the edge at which the drive stops
    if (hv_en_reg && hv_en_next) begin
      strobe_next = (samp_cnt_reg == '0);
      samp_cnt_next = (samp_cnt_reg == SAMP_LAST) ? '0 :
                      samp_cnt_reg + 5'(1);
    end
    // Half 0 is the drive-high half
    half_now = half_edge ? hv_drive_reg : ~hv_drive_reg;
    idx_now = half_edge ? '0 : sidx_reg;
    sidx_next = idx_now;
    if (strobe_next && idx_now < IDX_MAX) begin
      sidx_next = idx_now + IDX_W'(1);
    end
    tag_addr_next = tag_addr_reg;
    tag_ok_next = tag_ok_reg;
    tag_first_next = tag_first_reg;
    if (strobe_next) begin
      tag_addr_next = {half_now, idx_now[IDX_W-2:0]};
      // Only the rising part of each half is kept
      tag_ok_next = (acq_state_next == ACQ_RUN) && (idx_now < peak_reg);
      tag_first_next = (cyc_cnt_next == '0);
    end else if (adc_done) begin
      tag_ok_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_cnt_reg <= '0;
      strobe_reg <= 1'b0;
      sidx_reg <= '0;
      tag_addr_reg <= '0;
      tag_ok_reg <= 1'b0;
      tag_first_reg <= 1'b0;
    end else begin
      samp_cnt_reg <= samp_cnt_next;
      strobe_reg <= strobe_next;
      sidx_reg <= sidx_next;
      tag_addr_reg <= tag_addr_next;
      tag_ok_reg <= tag_ok_next;
      tag_first_reg <= tag_first_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulation memories, read-modify-write in two cycles
  logic [ACC_W-1:0] ir_mem [2*HALF_DEPTH];
  logic [ACC_W-1:0] la_mem [2*HALF_DEPTH];
  logic s1_vld_reg, s1_vld_next, s1_first_reg, s1_first_next;
  logic [AW-1:0] s1_addr_reg, s1_addr_next;
  logic [ACC_W-1:0] s1_ir_reg, s1_ir_next, s1_la_reg, s1_la_next;
  logic [ACC_W-1:0] ir_wr, la_wr;

  always_comb begin
    s1_vld_next = adc_done && tag_ok_reg;
    s1_addr_next = tag_addr_reg;
    s1_first_next = tag_first_reg;
    s1_ir_next = sext(adc_ir_data);
    s1_la_next = sext(adc_laser_data);
    // First cycle overwrites, so no separate clearing pass is needed
    ir_wr = s1_first_reg ? s1_ir_reg : ir_mem[s1_addr_reg] + s1_ir_reg;
    la_wr = s1_first_reg ? s1_la_reg : la_mem[s1_addr_reg] + s1_la_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (s1_vld_reg) begin
      ir_mem[s1_addr_reg] <= ir_wr;
      la_mem[s1_addr_reg] <= la_wr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_vld_reg <= 1'b0;
      s1_first_reg <= 1'b0;
      s1_addr_reg <= '0;
      s1_ir_reg <= '0;
      s1_la_reg <= '0;
    end else begin
      s1_vld_reg <= s1_vld_next;
      s1_first_reg <= s1_first_next;
      s1_addr_reg <= s1_addr_next;
      s1_ir_reg <= s1_ir_next;
      s1_la_reg <= s1_la_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acquisition sequence and readout
  logic [ZF_W-1:0] zf_reg, zf_next, dcnt_reg, dcnt_next;
  logic busy_reg, busy_next, done_reg, done_next;
  logic push, fifo_ready;
  logic [OUT_W-1:0] push_data;
  logic [AW-1:0] rd_addr;
  logic [ZF_W-1:0] lim;

  always_comb begin
    acq_state_next = acq_state_reg;
    cyc_cnt_next = cyc_cnt_reg;
    cyc_tgt_next = cyc_tgt_reg;
    peak_next = peak_reg;
    zf_next = zf_reg;
    dcnt_next = dcnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    push = 1'b0;
    push_data = '0;
    rd_addr = {(acq_state_reg == ACQ_H1), dcnt_reg[IDX_W-2:0]};
    lim = (acq_state_reg == ACQ_PRE || acq_state_reg == ACQ_POST) ?
          zf_reg : ZF_W'(peak_reg);
    case (acq_state_reg)
      ACQ_IDLE: begin
        if (acq_start && drv_state_reg == DRV_RUN) begin
          acq_state_next = ACQ_WAIT;
          busy_next = 1'b1;
          cyc_tgt_next = (cycle_target == '0) ? CYC_W'(1) :
                         (cycle_target > CYC_MAX) ? CYC_MAX : cycle_target;
          peak_next = (peak_samples > IDX_MAX) ? IDX_MAX : peak_samples;
          zf_next = zero_fill;
        end
      end
      ACQ_WAIT, ACQ_RUN: begin
        if (drv_state_reg != DRV_RUN) begin
          acq_state_next = ACQ_IDLE;
          busy_next = 1'b0;
        end else if (rise_edge) begin
          // Cycles are aligned to the rising drive edge
          if (acq_state_reg == ACQ_WAIT) begin
            acq_state_next = ACQ_RUN;
            cyc_cnt_next = '0;
          end else if (cyc_cnt_reg == cyc_tgt_reg - CYC_W'(1)) begin
            acq_state_next = ACQ_SETTLE;
            dcnt_next = '0;
          end else begin
            cyc_cnt_next = cyc_cnt_reg + CYC_W'(1);
          end
        end
      end
      ACQ_SETTLE: begin
        // Lets the last converter answer land before memories are read
        if (dcnt_reg == SETTLE_LAST) begin
          acq_state_next = ACQ_PRE;
          dcnt_next = '0;
        end else begin
          dcnt_next = dcnt_reg + ZF_W'(1);
        end
      end
      ACQ_PRE, ACQ_H0, ACQ_H1, ACQ_POST: begin
        if (acq_state_reg == ACQ_H0 || acq_state_reg == ACQ_H1) begin
          push_data = {ir_mem[rd_addr], la_mem[rd_addr],
                       rd_addr[AW-1] ^ pol_reg};
        end
        if (lim == '0 || (fifo_ready && dcnt_reg == lim - ZF_W'(1))) begin
          push = (lim != '0) && fifo_ready;
          dcnt_next = '0;
          case (acq_state_reg)
            ACQ_PRE: acq_state_next = ACQ_H0;
            ACQ_H0: acq_state_next = ACQ_H1;
            ACQ_H1: acq_state_next = ACQ_POST;
            default: begin
              acq_state_next = ACQ_IDLE;
              busy_next = 1'b0;
              done_next = 1'b1;
            end
          endcase
        end else if (fifo_ready) begin
          push = 1'b1;
          dcnt_next = dcnt_reg + ZF_W'(1);
        end
      end
      default: acq_state_next = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acq_state_reg <= ACQ_IDLE;
      cyc_cnt_reg <= '0;
      cyc_tgt_reg <= '0;
      peak_reg <= '0;
      zf_reg <= '0;
      dcnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      acq_state_reg <= acq_state_next;
      cyc_cnt_reg <= cyc_cnt_next;
      cyc_tgt_reg <= cyc_tgt_next;
      peak_reg <= peak_next;
      zf_reg <= zf_next;
      dcnt_reg <= dcnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  mda_fifo #(
    .W(OUT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_data(push_data),
    .in_ready(fifo_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready)
  );

  assign nvm_rd_en = nvm_rd_reg;
  assign nvm_addr = nvm_addr_reg;
  assign hv_enable = hv_en_reg;
  assign hv_drive = hv_drive_reg;
  assign pulse_count = pulse_cnt_reg;
  assign half_period = half_per_reg;
  assign drive_running = hv_en_reg;
  assign adc_strobe = strobe_reg;
  assign acq_busy = busy_reg;
  assign acq_done = done_reg;

endmodule

// [testbench/mda_chk.sv]
// Purpose: Port-level checks of the mirror drive acquisition block.
// Assumes: Bound to mda_top; one clock domain.
// Notes: A period change may land at a toggle, so both periods pass.
`timescale 1ns/10ps
module mda_chk
  import mda_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic drive_start, // Drive start
  input wire logic temp_valid, // New reading
  input wire logic [mda_pkg::TEMP_W-1:0] temp_code, // Reading
  input wire logic [mda_pkg::HP_W-1:0] res_half_period, // Resonance
  input wire logic nvm_rd_en, // Memory read
  input wire logic [mda_pkg::TEMP_W-1:0] nvm_addr, // Memory address
  input wire logic nvm_rd_valid, // Memory answer
  input wire logic hv_enable, // Driver enable
  input wire logic hv_drive, // Drive level
  input wire logic [mda_pkg::PCNT_W-1:0] pulse_count, // Pulses
  input wire logic [mda_pkg::HP_W-1:0] half_period, // Half period
  input wire logic drive_running, // Drive active
  input wire logic adc_strobe, // Strobe
  input wire logic acq_start, // Acquire
  input wire logic acq_busy, // Busy
  input wire logic out_valid, // Word present
  input wire logic out_ready // Word taken
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Length of the level that just ended
  logic drv_reg, drv_next;
  logic [HP_W-1:0] len_reg, len_next, hp_reg, hp_next;
  always_comb begin
    drv_next = hv_drive;
    len_next = len_reg + 18'h1;
    hp_next = hp_reg;
    if (hv_drive != drv_reg) begin
      len_next = 18'h1;
      hp_next = half_period;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      {drv_reg, len_reg, hp_reg} <= '0;
    else
      {drv_reg, len_reg, hp_reg} <= {drv_next, len_next, hp_next};
  end
  strobe_gap_a: assert property (
    adc_strobe |=> !adc_strobe [*8] ##1 !adc_strobe [*5] ##1
    (adc_strobe || !hv_enable)) else $error("strobe spacing wrong");
  strobe_first_a: assert property (
    $rose(hv_enable) |=> adc_strobe) else $error("first strobe late");
  strobe_drive_a: assert property (
    adc_strobe |-> hv_enable) else $error("strobe without drive");
  cond_read_a: assert property (
    (drive_start && !drive_running) || (temp_valid && drive_running)
    |=> nvm_rd_en && nvm_addr == $past(temp_code))
    else $error("condition read missing");
  load_first_a: assert property (
    $rose(hv_enable) |-> $past(nvm_rd_valid) && hv_drive &&
    pulse_count == 32'h1) else $error("drive start wrong");
  pulse_step_a: assert property (
    $rose(hv_drive) && $past(hv_enable) |->
    pulse_count == $past(pulse_count) + 32'h1)
    else $error("pulse count step wrong");
  half_len_a: assert property (
    hv_drive != drv_reg && hv_enable && $past(hv_enable, 2) |->
    len_reg == hp_reg || len_reg == half_period)
    else $error("half period length wrong");
  res_floor_a: assert property (
    hv_enable |-> half_period >= res_half_period + RES_MARGIN_CYC)
    else $error("drive too near resonance");
  acq_gate_a: assert property (
    acq_start && !acq_busy |=> acq_busy == $past(drive_running))
    else $error("acquisition gate wrong");
  out_hold_a: assert property (
    out_valid && !out_ready |=> out_valid) else $error("word dropped");
  cover property ($rose(hv_enable));
  cover property ($fell(acq_busy));
  cover property (out_valid && !out_ready);
endmodule
bind mda_top mda_chk u_chk (.sys_clk, .rst_b, .drive_start, .temp_valid,
  .temp_code, .res_half_period, .nvm_rd_en, .nvm_addr, .nvm_rd_valid,
  .hv_enable, .hv_drive, .pulse_count, .half_period, .drive_running,
  .adc_strobe, .acq_start, .acq_busy, .out_valid, .out_ready);

// [testbench/mda_far.sv]
// Purpose: Condition memory and converter pair beside the block.
// Assumes: Both answer three cycles after a request.
// Notes: Idle data lines show the inverse so stale words are caught.
`timescale 1ns/10ps
module mda_far
  import mda_pkg::*;
#(
  parameter logic [15:0] IRV = 16'h0003,
  parameter logic [15:0] LAV = 16'hfffe
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic nvm_rd_en, // Read request
  input wire logic [mda_pkg::TEMP_W-1:0] nvm_addr, // Read address
  output logic nvm_rd_valid, // Read answer
  output logic [mda_pkg::HP_W-1:0] nvm_rd_data, // Half period word
  input wire logic adc_strobe, // Shared strobe
  output logic adc_done, // Pair ready
  output logic [mda_pkg::ADC_W-1:0] adc_ir_data, // Infrared word
  output logic [mda_pkg::ADC_W-1:0] adc_laser_data // Laser word
);
  logic [2:0] mem_reg, mem_next, cnv_reg, cnv_next;
  logic [HP_W-1:0] word;
  always_comb begin
    mem_next = {mem_reg[1:0], nvm_rd_en};
    cnv_next = {cnv_reg[1:0], adc_strobe};
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      {mem_reg, cnv_reg} <= 6'h00;
    else
      {mem_reg, cnv_reg} <= {mem_next, cnv_next};
  end
  // Stored half period grows with the temperature address
  assign word = 18'h003e8 + {8'h00, nvm_addr, 2'h0};
  assign nvm_rd_valid = mem_reg[2];
  assign nvm_rd_data = mem_reg[2] ? word : ~word;
  assign adc_done = cnv_reg[2];
  assign adc_ir_data = cnv_reg[2] ? IRV : ~IRV;
  assign adc_laser_data = cnv_reg[2] ? LAV : ~LAV;
endmodule

// [testbench/mda_top_tb_top.sv]
// Purpose: Self-checking bench of the mirror drive acquisition block.
// Assumes: Short half-period limits so a run stays brief.
// Notes: Record is 2 zeros, 4 words per half, 2 zeros.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module mda_top_tb_top;
  import mda_pkg::*;
  localparam logic [15:0] IRV = 16'h0003;
  localparam logic [15:0] LAV = 16'hfffe;
  logic sys_clk, rst_b, drive_start, drive_stop, temp_valid, acq_start;
  logic nvm_rd_en, nvm_rd_valid, hv_enable, hv_drive, drive_running;
  logic adc_strobe, adc_done, acq_busy, acq_done, out_valid, out_ready;
  logic [7:0] temp_code, nvm_addr;
  logic [17:0] res_half_period, nvm_rd_data, half_period;
  logic [31:0] pulse_count;
  logic [15:0] adc_ir_data, adc_laser_data, zero_fill;
  logic [2:0] cycle_target;
  logic [4:0] peak_samples;
  logic [36:0] out_data;
  logic [7:0] tc [3] = '{8'h3c, 8'hff, 8'h00};
  logic [17:0] hp [3] = '{18'h004d8, 18'h007d0, 18'h0044c};
  int checks, bad_count, cyc, dn;
  mda_top #(.MAX_CYC(4), .HALF_DEPTH(16), .FIFO_DEPTH(8), .HALF_MIN(200),
    .HALF_MAX(2000)) dut (.sys_clk, .rst_b, .drive_start, .drive_stop,
    .temp_code, .temp_valid, .res_half_period, .nvm_rd_en, .nvm_addr,
    .nvm_rd_valid, .nvm_rd_data, .hv_enable, .hv_drive, .pulse_count,
    .half_period, .drive_running, .adc_strobe, .adc_done, .adc_ir_data,
    .adc_laser_data, .acq_start, .cycle_target, .peak_samples, .zero_fill,
    .acq_busy, .acq_done, .out_valid, .out_data, .out_ready);
  mda_far #(.IRV(IRV), .LAV(LAV)) far (.sys_clk, .rst_b, .nvm_rd_en,
    .nvm_addr, .nvm_rd_valid, .nvm_rd_data, .adc_strobe, .adc_done,
    .adc_ir_data, .adc_laser_data);
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (acq_done) dn++;
    if (cyc == 90000) begin
      bad_count++;
      results();
    end
  end
  task results();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bits: drive start, drive stop, temperature, acquire
  task go(input logic [3:0] p);
    @(posedge sys_clk);
    {drive_start, drive_stop, temp_valid, acq_start} <= p;
    @(posedge sys_clk);
    {drive_start, drive_stop, temp_valid, acq_start} <= 4'h0;
  endtask
  function automatic logic [36:0] word(input int i, input logic pol,
      input int n);
    if (i < 2 || i > 9)
      return 37'h0;
    return {18'(n * IRV), 18'(n * $signed(LAV)), pol ^ (i > 5)};
  endfunction
  // Stalls the consumer long enough for the FIFO to refuse
  task acq(input logic pol, input logic [2:0] tgt, input int n);
    int k;
    int i;
    @(posedge sys_clk);
    cycle_target <= tgt;
    out_ready <= 1'b0;
    go(4'h1);
    @(negedge sys_clk);
    `CHK(acq_busy, 1'b1)
    for (k = 0; k < 20000 && out_valid !== 1'b1; k++) @(negedge sys_clk);
    repeat (40) @(negedge sys_clk);
    @(posedge sys_clk);
    out_ready <= 1'b1;
    i = 0;
    for (k = 0; k < 300 && i < 12; k++) begin
      @(negedge sys_clk);
      if (out_valid === 1'b1) begin
        `CHK(out_data, word(i, pol, n))
        i++;
      end
    end
    `CHK(i, 12)
    for (k = 0; k < 100 && {acq_busy, out_valid} !== 2'b00; k++)
      @(negedge sys_clk);
    `CHK({acq_busy, out_valid}, 2'b00)
  endtask
  initial begin
    int k;
    int j;
    {rst_b, drive_start, drive_stop, temp_valid, acq_start} = 5'h00;
    temp_code = 8'h32;
    res_half_period = 18'h00064;
    cycle_target = 3'h2;
    peak_samples = 5'h04;
    zero_fill = 16'h0002;
    out_ready = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    `CHK(half_period, HALF_PER_RST)
    `CHK({hv_enable, pulse_count}, 33'h0)
    go(4'h1);
    repeat (2) @(negedge sys_clk);
    `CHK(acq_busy, 1'b0)
    go(4'h8);
    for (k = 0; k < 100 && hv_enable !== 1'b1; k++) @(negedge sys_clk);
    `CHK(half_period, 18'h004b0)
    repeat (3) @(posedge hv_drive);
    @(negedge sys_clk);
    `CHK(pulse_count, 32'h4)
    acq(1'b1, 3'h2, 2);
    for (j = 0; j < 3; j++) begin
      @(posedge sys_clk);
      temp_code <= tc[j];
      go(4'h2);
      for (k = 0; k < 6000 && half_period !== hp[j]; k++)
        @(negedge sys_clk);
      `CHK(half_period, hp[j])
    end
    go(4'h4);
    for (k = 0; k < 100 && hv_enable !== 1'b0; k++) @(negedge sys_clk);
    `CHK(hv_enable, 1'b0)
    repeat (14) @(posedge sys_clk);
    temp_code <= 8'h32;
    go(4'h8);
    for (k = 0; k < 100 && hv_enable !== 1'b1; k++) @(negedge sys_clk);
    acq(1'b0, 3'h0, 1);
    `CHK(dn, 2)
    results();
  end
endmodule
